/* File: hw/strap_pkg.sv */
package strap_pkg;

  // ----------------------------------------------------------------------
  // Strap defaults (internal pull levels)
  // ----------------------------------------------------------------------
  localparam logic       BOOT_DFLT     = 1'h0;
  localparam logic       IRQ_DFLT      = 1'h0;
  localparam logic       LINK_DFLT     = 1'h0;
  localparam logic       WPOL_DFLT     = 1'h0;
  localparam logic [2:0] TEST_DFLT     = 3'h7;

  // ----------------------------------------------------------------------
  // Driver configuration encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] IMP_NORMAL    = 2'h0;
  localparam logic [1:0] IMP_ANALOG    = 2'h2;
  localparam logic [2:0] DRIVE_DFLT    = 3'h5;
  localparam logic [2:0] DRIVE_MAX     = 3'h7;
  localparam logic [3:0] DRIVE_ACK     = 4'hE;
  localparam logic [1:0] STRAP_SETTLE  = 2'h2;

  typedef enum logic [1:0] {
    PULL_NONE,
    PULL_DOWN,
    PULL_UP
  } pull_t;

  typedef enum logic [1:0] {
    DRV_NORMAL,
    DRV_ANALOG,
    DRV_RESERVED
  } drv_mode_t;

endpackage

/* File: hw/strap_cfg_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Latched strap set handed from capture core to the top
interface strap_cfg_if;
  logic       boot_source_strap;
  logic       ext_interrupt_enable_strap;
  logic       link_rx_width_strap;
  logic       system_reg_write_policy_strap;
  logic [2:0] test_mode_straps;
  logic       pins_released;
  modport capture (output boot_source_strap, ext_interrupt_enable_strap, link_rx_width_strap,
                   system_reg_write_policy_strap, test_mode_straps, pins_released);
  modport user    (input boot_source_strap, ext_interrupt_enable_strap, link_rx_width_strap,
                   system_reg_write_policy_strap, test_mode_straps, pins_released);
endinterface
`default_nettype wire

/* File: hw/strap_capture.sv */
`timescale 1ns/10ps
`default_nettype none
module strap_capture
  import strap_pkg::*;
(
  input  wire logic       clk_in,        // System clock
  input  wire logic       rst_n_in,      // Async reset, active low
  input  wire logic [6:0] strap_pins_in, // Pad levels: boot,irq,link,wpol,tm1..tm3
  strap_cfg_if.capture    cfg            // Latched straps
);
  import strap_pkg::*;

  logic       armed_ff;
  logic [6:0] straps_ff;
  logic [1:0] settle_ff;
  logic       released_ff;
  wire        take = !armed_ff;

  // --------------------------------------------------------------------
  // Capture on first edge after release; hold until reset asserts again
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_ff  <= 1'b0;
      straps_ff <= {TEST_DFLT, WPOL_DFLT, LINK_DFLT, IRQ_DFLT, BOOT_DFLT};
    end else if (take) begin
      armed_ff  <= 1'b1;
      straps_ff <= strap_pins_in;
    end
  end                                                    // Frozen afterwards

  // Short settle delay before pads leave their strap role
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_ff   <= 2'h0;
      released_ff <= 1'b0;
    end else if (!released_ff) begin
      settle_ff   <= settle_ff + 2'h1;
      released_ff <= (settle_ff == STRAP_SETTLE);
    end
  end

  assign cfg.boot_source_strap             = straps_ff[0];
  assign cfg.ext_interrupt_enable_strap    = straps_ff[1];
  assign cfg.link_rx_width_strap           = straps_ff[2];
  assign cfg.system_reg_write_policy_strap = straps_ff[3];
  assign cfg.test_mode_straps              = straps_ff[6:4];
  assign cfg.pins_released                 = released_ff;
endmodule // strap_capture
`default_nettype wire

/* File: hw/reset_strap_mode_capture.sv */
`timescale 1ns/10ps
`default_nettype none
module reset_strap_mode_capture
  import strap_pkg::*;
(
  input  wire logic            clk_in,                         // System clock
  input  wire logic            rst_n_in,                       // Async reset, active low
  input  wire logic            boot_memory_select_pin_in,      // Boot strap pad level
  input  wire logic            bus_master_indicator_pin_in,    // Interrupt strap pad level
  input  wire logic            timer0_expired_pin_in,          // Link width strap pad level
  input  wire logic            bus_lock_pin_in,                // Write policy strap pad level
  input  wire logic [2:0]      link_block_done_in,             // Test strap pad levels 1..3
  input  wire logic [1:0]      impedance_mode_pins_in,         // Static impedance select
  input  wire logic [2:0]      drive_level_pins_in,            // Static drive strength code
  input  wire logic            cfg_write_in,                   // Config register write attempt
  output logic                 boot_from_memory_out,           // Start external memory boot
  output logic                 wait_external_boot_out,         // Idle for host/link boot
  output logic                 irq_enable_out,                 // External interrupts enabled
  output logic                 irq_level_sense_out,            // Interrupts level sensitive
  output logic                 link_rx_4bit_out,               // Link receive width 4-bit
  output logic                 cfg_write_allowed_out,          // Config write permitted now
  output logic [2:0]           test_mode_out,                  // Captured test straps
  output strap_pkg::drv_mode_t driver_mode_out,                // Decoded driver mode
  output logic [2:0]           drive_level_out,                // General pad strength
  output logic [2:0]           fixed_drive_level_out,          // Priority/emu/tdo/rst strength
  output logic [3:0]           ack_drive_level_out,            // Ack pin strength (doubled)
  output strap_pkg::pull_t     boot_lock_pull_out,             // Pull on boot and lock pads
  output strap_pkg::pull_t     driven_strap_pull_out,          // Pull on driven strap pads
  output strap_pkg::pull_t     test_strap_pull_out,            // Pull on test strap pads
  output logic                 strap_pins_functional_out       // Pads back to normal role
);
  import strap_pkg::*;

  strap_cfg_if cfg ();
  logic        wrote_ff;
  logic [2:0]  drive_ff;
  drv_mode_t   mode_ff;
  drv_mode_t   nxt_mode;

  // --------------------------------------------------------------------
  // Strap capture core
  // --------------------------------------------------------------------
  strap_capture u_cap (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .strap_pins_in ({link_block_done_in, bus_lock_pin_in, timer0_expired_pin_in,
                     bus_master_indicator_pin_in, boot_memory_select_pin_in}),
    .cfg           (cfg)
  );

  // Board keeps test straps at default; value only reported
  assign test_mode_out = cfg.test_mode_straps;

  // --------------------------------------------------------------------
  // Mode decode from latched straps
  // --------------------------------------------------------------------
  assign boot_from_memory_out   = cfg.pins_released && !cfg.boot_source_strap;
  assign wait_external_boot_out = cfg.pins_released && cfg.boot_source_strap;
  assign irq_enable_out         = cfg.ext_interrupt_enable_strap;
  assign irq_level_sense_out    = cfg.ext_interrupt_enable_strap;
  assign link_rx_4bit_out       = cfg.link_rx_width_strap;

  // One-shot write window unless the always-writable strap is set
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wrote_ff <= 1'b0;
    end else if (cfg_write_in && cfg.pins_released) begin
      wrote_ff <= 1'b1;
    end
  end
  assign cfg_write_allowed_out = cfg.pins_released &&
                                 (cfg.system_reg_write_policy_strap || !wrote_ff);

  // --------------------------------------------------------------------
  // Driver decode; pins are static so simple registering suffices
  // --------------------------------------------------------------------
  always_comb begin
    case (impedance_mode_pins_in)
      IMP_NORMAL: nxt_mode = DRV_NORMAL;
      IMP_ANALOG: nxt_mode = DRV_ANALOG;
      default:    nxt_mode = DRV_RESERVED;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_ff  <= DRV_ANALOG;
      drive_ff <= DRIVE_DFLT;
    end else begin
      mode_ff  <= nxt_mode;
      drive_ff <= drive_level_pins_in;
    end
  end

  assign driver_mode_out       = mode_ff;
  // Strength code only meaningful in normal mode; analog holds max
  assign drive_level_out       = (mode_ff == DRV_NORMAL) ? drive_ff : DRIVE_MAX;
  assign fixed_drive_level_out = DRIVE_MAX;
  assign ack_drive_level_out   = DRIVE_ACK;

  // --------------------------------------------------------------------
  // Pad pull control across the reset boundary
  // --------------------------------------------------------------------
  assign boot_lock_pull_out        = cfg.pins_released ? PULL_UP : PULL_DOWN;
  assign driven_strap_pull_out     = cfg.pins_released ? PULL_NONE : PULL_DOWN;
  assign test_strap_pull_out       = cfg.pins_released ? PULL_NONE : PULL_UP;
  assign strap_pins_functional_out = cfg.pins_released;

endmodule // reset_strap_mode_capture
`default_nettype wire

/* File: sim/strap_capture_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module strap_capture_sva
  import strap_pkg::*;
(
  input wire logic clk_in, rst_n_in, boot_memory_select_pin_in, bus_master_indicator_pin_in, // Clock, pads
  input wire logic [1:0] impedance_mode_pins_in, // Impedance select
  input wire logic [2:0] drive_level_pins_in, drive_level_out, fixed_drive_level_out, test_mode_out, // Codes
  input wire logic [3:0] ack_drive_level_out, // Ack strength
  input wire logic boot_from_memory_out, wait_external_boot_out, irq_enable_out, link_rx_4bit_out, // Modes
  input wire logic cfg_write_allowed_out, strap_pins_functional_out, // Window, release
  input wire strap_pkg::drv_mode_t driver_mode_out, // Driver mode
  input wire strap_pkg::pull_t boot_lock_pull_out, driven_strap_pull_out // Pulls
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Release edge, and the point where the pads are surely handed back
  sequence s_release; $rose(rst_n_in); endsequence
  sequence s_settled; s_release ##5 strap_pins_functional_out; endsequence
  property p_fixed; fixed_drive_level_out == DRIVE_MAX && ack_drive_level_out == DRIVE_ACK; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed strength");
  property p_latch; s_release |=> irq_enable_out == $past(bus_master_indicator_pin_in); endproperty
  a_latch: assert property (p_latch) else $error("strap not latched");
  property p_hold; strap_pins_functional_out |=> $stable({irq_enable_out, link_rx_4bit_out, test_mode_out}); endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
  property p_release; s_release |-> !strap_pins_functional_out ##[1:4] strap_pins_functional_out; endproperty
  a_release: assert property (p_release) else $error("pads not released");
  property p_pulls; strap_pins_functional_out |-> boot_lock_pull_out == PULL_UP && driven_strap_pull_out == PULL_NONE;
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull after release");
  property p_boot; s_settled |-> wait_external_boot_out == $past(boot_memory_select_pin_in, 5)
    && boot_from_memory_out != wait_external_boot_out; endproperty
  a_boot: assert property (p_boot) else $error("boot select");
  // Static pins must sit still for two edges before the code is trusted
  property p_drive; (impedance_mode_pins_in == IMP_NORMAL && $stable(drive_level_pins_in))[*2]
    |-> driver_mode_out == DRV_NORMAL && drive_level_out == drive_level_pins_in; endproperty
  a_drive: assert property (p_drive) else $error("drive code");
  property p_once; strap_pins_functional_out && !cfg_write_allowed_out |=> !cfg_write_allowed_out; endproperty
  a_once: assert property (p_once) else $error("write window reopened");
endmodule // strap_capture_sva
bind reset_strap_mode_capture strap_capture_sva chk (.*);
`default_nettype wire

/* File: sim/strap_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module strap_board_model
  import strap_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire strap_pkg::pull_t lock_pull_in, drv_pull_in, test_pull_in, // Device pulls
  input wire logic [3:0] ovr_en_in, ovr_val_in, // Board strap resistors
  output logic [6:0] pads_out // Pad levels
);
  logic wander_ff;
  // Unpulled pads wander so a stale level never passes for a strap
  initial wander_ff = 1'b0;
  always @(posedge clk_in) wander_ff <= !wander_ff;
  function automatic logic lvl(input pull_t p, input logic w);
    return (p == PULL_UP) ? 1'b1 : (p == PULL_DOWN) ? 1'b0 : w;
  endfunction
  // Stronger board resistors win over the weak internal pulls
  assign pads_out[3:0] = (ovr_en_in & ovr_val_in) | (~ovr_en_in & {lvl(lock_pull_in, wander_ff),
    lvl(drv_pull_in, wander_ff), lvl(drv_pull_in, wander_ff), lvl(lock_pull_in, wander_ff)});
  assign pads_out[6:4] = {3{lvl(test_pull_in, wander_ff)}};
endmodule // strap_board_model
`default_nettype wire

/* File: sim/reset_strap_mode_capture_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module reset_strap_mode_capture_bench;
  import strap_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, cfg_write_in = 1'b0;
  logic [1:0] impedance_mode_pins_in = IMP_ANALOG;
  logic [2:0] drive_level_pins_in = DRIVE_DFLT;
  logic [3:0] ovr_en = 4'h0, ovr_val = 4'h0, ack_drive_level_out;
  logic [6:0] pads;
  logic boot_memory_select_pin_in, bus_master_indicator_pin_in, timer0_expired_pin_in, bus_lock_pin_in;
  logic [2:0] link_block_done_in, test_mode_out, drive_level_out, fixed_drive_level_out;
  logic boot_from_memory_out, wait_external_boot_out, irq_enable_out, irq_level_sense_out, link_rx_4bit_out;
  logic cfg_write_allowed_out, strap_pins_functional_out;
  drv_mode_t driver_mode_out;
  pull_t boot_lock_pull_out, driven_strap_pull_out, test_strap_pull_out;
  int n_errors = 0, check_count = 0;
  always #2.5 clk_in = !clk_in;
  strap_board_model board (.clk_in(clk_in), .lock_pull_in(boot_lock_pull_out), .drv_pull_in(driven_strap_pull_out),
    .test_pull_in(test_strap_pull_out), .ovr_en_in(ovr_en), .ovr_val_in(ovr_val), .pads_out(pads));
  assign {link_block_done_in, bus_lock_pin_in, timer0_expired_pin_in, bus_master_indicator_pin_in,
    boot_memory_select_pin_in} = pads;
  reset_strap_mode_capture dut (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic boot_with(input logic [3:0] en, input logic [3:0] val);
    rst_n_in = 1'b0;
    ovr_en = en;
    ovr_val = val;
    cyc(3);
    chk({boot_lock_pull_out, driven_strap_pull_out, test_strap_pull_out}, {PULL_DOWN, PULL_DOWN, PULL_UP});
    rst_n_in = 1'b1;
    cyc(6);
    chk({strap_pins_functional_out, test_mode_out}, {1'b1, TEST_DFLT});
  endtask
  task automatic t_defaults;
    boot_with(4'h0, 4'h0);
    chk({boot_from_memory_out, wait_external_boot_out, irq_enable_out, irq_level_sense_out}, 4'h8);
    chk(link_rx_4bit_out, 1'b0);
    chk({boot_lock_pull_out, driven_strap_pull_out, test_strap_pull_out}, {PULL_UP, PULL_NONE, PULL_NONE});
  endtask
  // One write closes the window for good
  task automatic t_one_write;
    chk(cfg_write_allowed_out, 1'b1);
    cfg_write_in = 1'b1;
    cyc(1);
    cfg_write_in = 1'b0;
    cyc(2);
    chk(cfg_write_allowed_out, 1'b0);
  endtask
  // The four resistor straps overridden high (test straps left on pulls), then the pads flip after capture
  task automatic t_override;
    boot_with(4'hF, 4'hF);
    chk({wait_external_boot_out, irq_enable_out, irq_level_sense_out, link_rx_4bit_out}, 4'hF);
    ovr_val = 4'h0;
    cfg_write_in = 1'b1;
    cyc(3);
    cfg_write_in = 1'b0;
    chk({irq_enable_out, link_rx_4bit_out, cfg_write_allowed_out}, 3'h7);
  endtask
  task automatic t_drive;
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 8; d++) begin
        impedance_mode_pins_in = m[1:0];
        drive_level_pins_in = d[2:0];
        cyc(2);
        chk(driver_mode_out, m == 0 ? DRV_NORMAL : m == 2 ? DRV_ANALOG : DRV_RESERVED);
        chk(drive_level_out, m == 0 ? d[2:0] : DRIVE_MAX);
        chk({fixed_drive_level_out, ack_drive_level_out}, {DRIVE_MAX, DRIVE_ACK});
      end
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_defaults();
    t_one_write();
    t_override();
    t_drive();
    complete_run();
  end
  // Whole run is near 100 cycles; this cuts a hang
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule // reset_strap_mode_capture_bench
`default_nettype wire
